// File: src/fbmc_pkg.sv
// Constants and types shared by the mode-control block
package fbmc_pkg;

	// ----------------------------------------
	// Clock and widths
	// ----------------------------------------
	localparam int unsigned CLK_NS = 8;
	localparam int unsigned WDT_W  = 16;
	localparam int unsigned RT_W   = 6;
	localparam int unsigned SC_W   = 14;

	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [7:0] IDX_SCFG_LO = 8'h06;
	localparam logic [7:0] IDX_SCFG_HI = 8'h07;
	localparam logic [7:0] IDX_RT_SET  = 8'h08;
	localparam logic [7:0] IDX_RT_CLR  = 8'h09;
	localparam logic [7:0] IDX_STATUS  = 8'h0A;

	// ----------------------------------------
	// Run-time control bits
	// ----------------------------------------
	localparam int unsigned RT_START = 0;
	localparam int unsigned RT_IACK  = 1;
	localparam int unsigned RT_GO    = 2;
	localparam int unsigned RT_LEAVE = 3;
	localparam int unsigned RT_SWAP  = 4;
	localparam int unsigned RT_WDR   = 5;

	// ----------------------------------------
	// Static configuration bits
	// ----------------------------------------
	localparam int unsigned SC_START_DIS = 0;
	localparam int unsigned SC_STOP_DIS  = 1;
	localparam int unsigned SC_TSDR_LO   = 2;
	localparam int unsigned SC_IRQ_POL   = 4;
	localparam int unsigned SC_EARLY     = 5;
	localparam int unsigned SC_SYNC      = 6;
	localparam int unsigned SC_FREEZE    = 7;
	localparam int unsigned SC_PROTO     = 8;
	localparam int unsigned SC_IRQ_TB    = 9;
	localparam int unsigned SC_USER_TB   = 10;
	localparam int unsigned SC_WDT_TST   = 11;
	localparam int unsigned SC_PRM_BUF   = 12;
	localparam int unsigned SC_SPEC_CLR  = 13;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [SC_W-1:0] SCFG_RST = 14'h0000;
	localparam logic [RT_W-1:0] RT_RST   = 6'h00;

	// ----------------------------------------
	// Controller state
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_OFFLINE = 3'h1,
		ST_ONLINE  = 3'h2,
		ST_DRAIN   = 3'h4
	} fbmc_state_t;

endpackage

// File: src/fbmc_top.sv
// Mode-control register block with AHB-Lite register access
// Notes on behaviour
// - Static configuration writes take effect only while offline.
// - Static configuration spans two byte registers with the listed fields.
// - Special clear lets data exchange accept zero-length data telegrams.
// - Special parameter buffer routes parameter data to its own buffer.
// - Run-time bits are set at one address and cleared at another, bit by bit.
// - Start leaves offline, starts the timers and clears go-offline.
// - End of interrupt drops the interrupt output and then clears itself.
// - Go-offline waits for the current request, goes offline, clears itself.
// - Leave-master forces the protocol machine to await parameters, clears itself.
// - Swap-enable decides whether config-accepted swaps the config buffers.
// - Watchdog reload presets the user watchdog, then clears itself.
// - The user watchdog is sixteen bits and runs in protocol mode while online.
`timescale 1ns/100ps
module fbmc_top
	import fbmc_pkg::*;
#(
	parameter int unsigned TB_FAST_NS = 1000000,
	parameter int unsigned TB_SLOW_NS = 10000000
) (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic [31:0]            hrdata,
	output logic                   hresp,
	input  wire logic              request_busy,
	input  wire logic              irq_event,
	input  wire logic              cfg_ok_cmd,
	input  wire logic              in_data_exchange,
	input  wire logic [WDT_W-1:0]  user_watchdog_preset,
	output logic                   online,
	output logic                   start_timers,
	output logic                   irq_out,
	output logic                   force_wait_prm,
	output logic                   swap_cfg_buffers,
	output logic                   accept_empty_data,
	output logic                   prm_direct_buffer,
	output logic [SC_W-1:0]        static_config,
	output logic                   user_watchdog_expired
);

	localparam int unsigned TB_FAST_CYC = (TB_FAST_NS / CLK_NS > 0) ? TB_FAST_NS / CLK_NS : 1;
	localparam int unsigned TB_SLOW_CYC = (TB_SLOW_NS / CLK_NS > 0) ? TB_SLOW_NS / CLK_NS : 1;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	logic        dp_valid_q;
	logic        dp_write_q;
	logic [7:0]  dp_idx_q;
	logic        rd_done_q;
	logic [31:0] hrdata_q;
	logic        accept;
	logic        wr_lo;
	logic        wr_hi;
	logic        wr_set;
	logic        wr_clr;
	logic [RT_W-1:0] wmask;

	assign accept = hsel && htrans[1] && hready;
	// Reads take one wait state so they see writes from the cycle before
	assign hreadyout = !(dp_valid_q && !dp_write_q && !rd_done_q);
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dp_valid_q <= 1'b0;
			dp_write_q <= 1'b0;
			dp_idx_q <= 8'h00;
		end else if (hreadyout) begin
			dp_valid_q <= accept;
			dp_write_q <= hwrite;
			dp_idx_q <= haddr[9:2];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_done_q <= 1'b0;
		end else begin
			rd_done_q <= dp_valid_q && !dp_write_q && !rd_done_q;
		end
	end

	function automatic logic dp_wr(input logic [7:0] idx, input logic v, input logic w,
		input logic [7:0] want);
		dp_wr = v && w && (idx == want);
	endfunction

	assign wr_lo  = dp_wr(dp_idx_q, dp_valid_q, dp_write_q, IDX_SCFG_LO);
	assign wr_hi  = dp_wr(dp_idx_q, dp_valid_q, dp_write_q, IDX_SCFG_HI);
	assign wr_set = dp_wr(dp_idx_q, dp_valid_q, dp_write_q, IDX_RT_SET);
	assign wr_clr = dp_wr(dp_idx_q, dp_valid_q, dp_write_q, IDX_RT_CLR);
	assign wmask = hwdata[RT_W-1:0];

	// ----------------------------------------
	// Static configuration
	// ----------------------------------------
	fbmc_state_t state_q;
	logic [SC_W-1:0] scfg_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scfg_q <= SCFG_RST;
		end else if (state_q == ST_OFFLINE) begin
			if (wr_lo) begin
				scfg_q[7:0] <= hwdata[7:0];
			end
			if (wr_hi) begin
				scfg_q[SC_W-1:8] <= hwdata[SC_W-9:0];
			end
		end
	end

	assign static_config = scfg_q;

	// ----------------------------------------
	// Run-time control bits
	// ----------------------------------------
	logic [RT_W-1:0] rt_q;
	logic [RT_W-1:0] rt_d;
	logic [RT_W-1:0] hw_clr;
	logic            start_take;
	logic            drain_done;

	assign start_take = (state_q == ST_OFFLINE) && rt_q[RT_START];
	assign drain_done = (state_q == ST_DRAIN) && !request_busy;

	always_comb begin
		hw_clr = '0;
		hw_clr[RT_IACK] = rt_q[RT_IACK];
		hw_clr[RT_LEAVE] = rt_q[RT_LEAVE];
		hw_clr[RT_WDR] = rt_q[RT_WDR];
		hw_clr[RT_GO] = start_take || drain_done;
		// Start stays set while online so a fresh start needs a fresh write
		hw_clr[RT_START] = drain_done;
	end

	always_comb begin
		rt_d = rt_q & ~hw_clr;
		if (wr_clr) begin
			rt_d = rt_d & ~wmask;
		end
		// A software set in the same cycle as a self-clear is kept
		if (wr_set) begin
			rt_d = rt_d | wmask;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rt_q <= RT_RST;
		end else begin
			rt_q <= rt_d;
		end
	end

	// ----------------------------------------
	// Offline and online control
	// ----------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= ST_OFFLINE;
		end else begin
			unique case (state_q)
				ST_OFFLINE: begin
					if (start_take) begin
						state_q <= ST_ONLINE;
					end
				end
				ST_ONLINE: begin
					if (rt_q[RT_GO]) begin
						state_q <= ST_DRAIN;
					end
				end
				ST_DRAIN: begin
					if (!request_busy) begin
						state_q <= ST_OFFLINE;
					end
				end
				default: begin
					state_q <= ST_OFFLINE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			online <= 1'b0;
			start_timers <= 1'b0;
		end else begin
			online <= (state_q != ST_OFFLINE);
			start_timers <= start_take;
		end
	end

	// ----------------------------------------
	// Interrupt output and action pulses
	// ----------------------------------------
	logic irq_pend_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_pend_q <= 1'b0;
		end else if (irq_event) begin
			irq_pend_q <= 1'b1;
		end else if (rt_q[RT_IACK]) begin
			irq_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_out <= 1'b0;
			force_wait_prm <= 1'b0;
			swap_cfg_buffers <= 1'b0;
			accept_empty_data <= 1'b0;
			prm_direct_buffer <= 1'b0;
		end else begin
			irq_out <= irq_pend_q ~^ scfg_q[SC_IRQ_POL];
			force_wait_prm <= rt_q[RT_LEAVE];
			swap_cfg_buffers <= cfg_ok_cmd && rt_q[RT_SWAP];
			accept_empty_data <= scfg_q[SC_SPEC_CLR] && in_data_exchange;
			prm_direct_buffer <= scfg_q[SC_PRM_BUF];
		end
	end

	// ----------------------------------------
	// User watchdog
	// ----------------------------------------
	fbmc_wdt_if #(.W(WDT_W)) wi ();
	logic [31:0] tb_cnt_q;
	logic [31:0] tb_lim;

	assign tb_lim = scfg_q[SC_USER_TB] ? TB_SLOW_CYC - 1 : TB_FAST_CYC - 1;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tb_cnt_q <= '0;
		end else if (tb_cnt_q >= tb_lim) begin
			tb_cnt_q <= '0;
		end else begin
			tb_cnt_q <= tb_cnt_q + 32'h00000001;
		end
	end

	assign wi.tick = (tb_cnt_q >= tb_lim);
	assign wi.preset = user_watchdog_preset;
	assign wi.reload = rt_q[RT_WDR];
	assign wi.run = scfg_q[SC_PROTO] && (state_q != ST_OFFLINE);
	assign user_watchdog_expired = wi.expired;

	fbmc_user_wdt #(.W(WDT_W)) u_wdt (
		.clk     (clk),
		.sys_rst (sys_rst),
		.wi      (wi.wdt)
	);

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hrdata_q <= 32'h00000000;
		end else if (dp_valid_q && !dp_write_q && !rd_done_q) begin
			unique case (dp_idx_q)
				IDX_SCFG_LO: hrdata_q <= {24'h000000, scfg_q[7:0]};
				IDX_SCFG_HI: hrdata_q <= {26'h0000000, scfg_q[SC_W-1:8]};
				IDX_STATUS: hrdata_q <= {wi.count, 2'h0, rt_q, 5'h00,
					wi.expired, irq_pend_q, (state_q != ST_OFFLINE)};
				default: hrdata_q <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	scfg_lock_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		state_q != ST_OFFLINE |=> $stable(scfg_q))
		else $error("static config changed while online");

	start_online_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		start_take |=> state_q == ST_ONLINE ##1 online)
		else $error("start did not bring controller online");

	start_go_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		start_take && !(wr_set && wmask[RT_GO]) |=> !rt_q[RT_GO])
		else $error("start left go-offline set");

	iack_clear_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		rt_q[RT_IACK] && !irq_event && !(wr_set && wmask[RT_IACK])
		|=> !rt_q[RT_IACK] && !irq_pend_q)
		else $error("end of interrupt not completed");

	drain_wait_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		state_q == ST_DRAIN && request_busy |=> state_q == ST_DRAIN)
		else $error("went offline during a request");

	leave_pulse_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		rt_q[RT_LEAVE] |=> force_wait_prm)
		else $error("leave-master not forwarded");

	swap_gate_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		cfg_ok_cmd |=> swap_cfg_buffers == $past(rt_q[RT_SWAP]))
		else $error("buffer swap not gated by enable");

	set_clr_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		wr_set && wmask[RT_SWAP] |=> rt_q[RT_SWAP] ##1 rt_q[RT_SWAP] || $past(wr_clr))
		else $error("swap-enable set lost");

	zero_keep_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(wr_set || wr_clr) && !wmask[RT_SWAP] |=> $stable(rt_q[RT_SWAP]))
		else $error("zero bit changed run-time control");

	go_offline_c: cover property (
		@(posedge clk) disable iff (sys_rst)
		state_q == ST_ONLINE ##1 state_q == ST_DRAIN [*2] ##1 state_q == ST_OFFLINE);

	start_c: cover property (
		@(posedge clk) disable iff (sys_rst) start_take);

	swap_c: cover property (
		@(posedge clk) disable iff (sys_rst) swap_cfg_buffers);

endmodule

// File: src/fbmc_user_wdt.sv
// User watchdog down-counter
`timescale 1ns/100ps
module fbmc_user_wdt
	import fbmc_pkg::*;
#(
	parameter int unsigned W = WDT_W
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	fbmc_wdt_if.wdt   wi
);

	logic [W-1:0] count_q;

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	// reload from preset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_q <= '0;
		end else if (wi.reload) begin
			count_q <= wi.preset;
		end else if (wi.run && wi.tick && count_q != '0) begin
			count_q <= count_q - 1'b1;
		end
	end

	assign wi.count = count_q;
	assign wi.expired = wi.run && (count_q == '0);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	wdt_reload_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		wi.reload |=> count_q == $past(wi.preset))
		else $error("watchdog not reloaded from preset");

	wdt_hold_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		!wi.reload && !wi.run |=> $stable(count_q))
		else $error("watchdog moved while stopped");

	wdt_expire_c: cover property (
		@(posedge clk) disable iff (sys_rst) wi.expired);

endmodule

// File: src/fbmc_wdt_if.sv
// Link between the control logic and the user watchdog
`timescale 1ns/100ps
interface fbmc_wdt_if #(parameter int unsigned W = 16);
	logic [W-1:0] preset;
	logic         reload;
	logic         run;
	logic         tick;
	logic [W-1:0] count;
	logic         expired;

	modport ctl (output preset, output reload, output run, output tick,
		input count, input expired);
	modport wdt (input preset, input reload, input run, input tick,
		output count, output expired);
endinterface

// File: verification/fbmc_tb.sv
// Self-checking bench for the mode-control register block
`timescale 1ns/100ps
module testbench
	import fbmc_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic             clk, sys_rst, hsel, hwrite, hreadyout, hresp;
	logic [31:0]      haddr, hwdata, hrdata, rd;
	logic [1:0]       htrans;
	logic [2:0]       hsize;
	logic             request_busy, irq_event, cfg_ok_cmd, in_data_exchange;
	logic [WDT_W-1:0] user_watchdog_preset;
	logic             online, start_timers, irq_out, force_wait_prm, swap_cfg_buffers;
	logic             accept_empty_data, prm_direct_buffer, user_watchdog_expired;
	logic [SC_W-1:0]  static_config;
	int               mismatches, num_checks, n_start, n_force, n_swap, n_wait;

	// Short tick periods keep the watchdog run brief
	fbmc_top #(.TB_FAST_NS(16), .TB_SLOW_NS(40)) DUT (
		.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.request_busy(request_busy), .irq_event(irq_event), .cfg_ok_cmd(cfg_ok_cmd),
		.in_data_exchange(in_data_exchange), .user_watchdog_preset(user_watchdog_preset),
		.online(online), .start_timers(start_timers), .irq_out(irq_out),
		.force_wait_prm(force_wait_prm), .swap_cfg_buffers(swap_cfg_buffers),
		.accept_empty_data(accept_empty_data), .prm_direct_buffer(prm_direct_buffer),
		.static_config(static_config), .user_watchdog_expired(user_watchdog_expired));

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	// Pulse outputs last one cycle, so they are counted as they pass
	always @(posedge clk) begin
		if (start_timers === 1'h1) n_start++;
		if (force_wait_prm === 1'h1) n_force++;
		if (swap_cfg_buffers === 1'h1) n_swap++;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("Checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// One single AHB-Lite transfer; entered and left just after a rising edge
	task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
		output logic [31:0] d);
		hsel   <= 1'h1;
		haddr  <= {22'h000000, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= 3'h2;
		// Waits are unbounded; only the hang guard ends a stuck transfer
		do begin
			@(posedge clk);
		end while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge clk);
		end while (hreadyout !== 1'h1);
		d = hrdata;
		check(hresp, 1'h0);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		logic [31:0] d;
		bus(idx, 1'h1, wd, d);
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] d;
		bus(idx, 1'h0, 32'h00000000, d);
		check(d & mask, exp);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic pulse_cfg_ok;
		cfg_ok_cmd <= 1'h1;
		@(posedge clk);
		cfg_ok_cmd <= 1'h0;
		cyc(3);
	endtask

	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#100000;
		mismatches++;
		results;
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		sys_rst = 1'h1; hsel = 1'h0; haddr = 32'h00000000; htrans = 2'h0;
		hwrite = 1'h0; hsize = 3'h2; hwdata = 32'h00000000; request_busy = 1'h0;
		irq_event = 1'h0; cfg_ok_cmd = 1'h0; in_data_exchange = 1'h1;
		user_watchdog_preset = 16'h0005;
		mismatches = 0; num_checks = 0; n_start = 0; n_force = 0; n_swap = 0;
		cyc(6);
		sys_rst <= 1'h0;
		@(posedge clk);
		rdc(IDX_SCFG_LO, 32'h000000FF, 32'h00000000);
		rdc(IDX_SCFG_HI, 32'h0000003F, 32'h00000000);
		rdc(IDX_STATUS, 32'h00003F01, 32'h00000000);
		check(irq_out, 1'h1);
		// Offline configuration, junk in the upper data bits
		wr(IDX_SCFG_LO, 32'hFFFFFFE6);
		wr(IDX_SCFG_HI, 32'hFFFFFF35);
		cyc(2);
		check(static_config, 14'h35E6);
		rdc(IDX_SCFG_LO, 32'hFFFFFFFF, 32'h000000E6);
		rdc(IDX_SCFG_HI, 32'hFFFFFFFF, 32'h00000035);
		check(prm_direct_buffer, 1'h1);
		check(accept_empty_data, 1'h1);
		in_data_exchange <= 1'h0;
		cyc(3);
		check(accept_empty_data, 1'h0);
		// Start, then a locked configuration
		wr(IDX_RT_SET, 32'h00000001);
		cyc(4);
		check(online, 1'h1);
		check(n_start, 1);
		rdc(IDX_STATUS, 32'h00003F01, 32'h00000101);
		wr(IDX_SCFG_LO, 32'h00000000);
		cyc(2);
		check(static_config, 14'h35E6);
		// Set and clear masks, dead bits 7 and 6
		wr(IDX_RT_SET, 32'h000000D0);
		rdc(IDX_STATUS, 32'h00003F00, 32'h00001100);
		wr(IDX_RT_CLR, 32'h000000C0);
		rdc(IDX_STATUS, 32'h00003F00, 32'h00001100);
		pulse_cfg_ok;
		check(n_swap, 1);
		wr(IDX_RT_CLR, 32'h00000010);
		rdc(IDX_STATUS, 32'h00003F00, 32'h00000100);
		pulse_cfg_ok;
		check(n_swap, 1);
		// Interrupt raised, then ended; polarity is active low here
		irq_event <= 1'h1;
		@(posedge clk);
		irq_event <= 1'h0;
		cyc(3);
		check(irq_out, 1'h0);
		wr(IDX_RT_SET, 32'h00000002);
		cyc(3);
		check(irq_out, 1'h1);
		rdc(IDX_STATUS, 32'h00003F00, 32'h00000100);
		wr(IDX_RT_SET, 32'h00000008);
		cyc(3);
		check(n_force, 1);
		rdc(IDX_STATUS, 32'h00003F00, 32'h00000100);
		// User watchdog: reload, run down, reload with a wide value
		wr(IDX_RT_SET, 32'h00000020);
		cyc(2);
		check(user_watchdog_expired, 1'h0);
		for (int i = 0; i < 200 && user_watchdog_expired !== 1'h1; i++) @(posedge clk);
		check(user_watchdog_expired, 1'h1);
		user_watchdog_preset <= 16'h8003;
		wr(IDX_RT_SET, 32'h00000020);
		bus(IDX_STATUS, 1'h0, 32'h00000000, rd);
		check(rd[31:16] > 16'h7FF0 && rd[31:16] <= 16'h8003, 1'h1);
		check(rd[13:8], 6'h01);
		check(user_watchdog_expired, 1'h0);
		// Go offline waits for the busy request
		request_busy <= 1'h1;
		wr(IDX_RT_SET, 32'h00000004);
		cyc(10);
		check(online, 1'h1);
		request_busy <= 1'h0;
		cyc(4);
		check(online, 1'h0);
		rdc(IDX_STATUS, 32'h00003F01, 32'h00000000);
		// Writable again offline; active-high polarity idles low
		wr(IDX_SCFG_LO, 32'h00000010);
		cyc(2);
		check(static_config, 14'h3510);
		check(irq_out, 1'h0);
		// Clear the user timebase bit so the watchdog takes the fast tick
		wr(IDX_SCFG_HI, 32'h00000031);
		cyc(2);
		check(static_config, 14'h3110);
		// A pending go-offline is dropped by start
		wr(IDX_RT_SET, 32'h00000004);
		wr(IDX_RT_SET, 32'h00000001);
		cyc(4);
		check(online, 1'h1);
		check(n_start, 2);
		rdc(IDX_STATUS, 32'h00003F01, 32'h00000101);
		// Fast tick of two cycles: a preset of four runs out in about eight
		user_watchdog_preset <= 16'h0004;
		wr(IDX_RT_SET, 32'h00000020);
		n_wait = 0;
		while (n_wait < 40 && user_watchdog_expired !== 1'h1) begin
			@(posedge clk);
			n_wait++;
		end
		check(n_wait > 6 && n_wait < 14, 1'h1);
		results;
	end
endmodule
